// [logic/obpd_pkg.sv]
// Constants for the output buffer and power-down mask register slice.
package obpd_pkg;

  // ***************************************************************
  // Register addresses on the serial control port
  // ***************************************************************
  localparam logic [6:0] ADDR_BUF_OFF_LOW  = 7'h0a;
  localparam logic [6:0] ADDR_BUF_OFF_MID  = 7'h0b;
  localparam logic [6:0] ADDR_BUF_OFF_HIGH = 7'h0c;
  localparam logic [6:0] ADDR_SLEEP_MASK   = 7'h0d;
  localparam logic [6:0] ADDR_SYNC_REF     = 7'h0e;

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [7:0] RST_BUF_OFF    = 8'h00;
  localparam logic [7:0] RST_SLEEP_MASK = 8'h00;
  localparam logic [7:0] RST_SYNC_REF   = 8'h00;
  localparam logic [7:0] READ_UNMAPPED  = 8'h00;

  // ***************************************************************
  // Field positions, sleep mask register
  // ***************************************************************
  localparam int KEEP_BIAS_CURRENTS_BIT       = 5;
  localparam int KEEP_SAMPLE_CLOCK_BUFFER_BIT = 3;
  localparam int KEEP_REFERENCE_AMPLIFIER_BIT = 2;
  localparam int DROP_BANDGAP_IN_SLEEP_BIT    = 1;

  // ***************************************************************
  // Field positions, sync and reference control register
  // ***************************************************************
  localparam int PIN_SYNC_SELECT_BIT           = 7;
  localparam int REG_SYNC_TRIGGER_BIT          = 6;
  localparam int REG_SYNC_ENABLE_BIT           = 5;
  localparam int REFERENCE_SOURCE_CONTROL_BIT  = 3;
  localparam int REFERENCE_SELECT_HI_BIT       = 2;
  localparam int REFERENCE_SELECT_LO_BIT       = 1;
  localparam int SINGLE_ENDED_CLOCK_SELECT_BIT = 0;

  // Reference select codes.
  localparam logic [1:0] REF_INTERNAL     = 2'h0;
  localparam logic [1:0] REF_EXT_BUFFERED = 2'h1;
  localparam logic [1:0] REF_EXTERNAL     = 2'h2;

  // ***************************************************************
  // Serial frame layout: read flag, 7 address bits, 8 data bits
  // ***************************************************************
  localparam logic [3:0] HEAD_LAST_BIT  = 4'h7;
  localparam logic [3:0] FRAME_LAST_BIT = 4'hf;
  localparam int         READ_FLAG_BIT  = 7;

  // Serial port sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_HEAD,
    ST_DATA,
    ST_DONE
  } obpd_spi_state_e;

endpackage

// [logic/obpd_sync.sv]
// Two flip-flop synchroniser for a group of asynchronous pin levels.
module obpd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  // ***************************************************************
  // One two-stage chain per bit
  // ***************************************************************
  genvar g;
  generate
    for (g = 0; g < WIDTH; g = g + 1)
    begin : g_bit
      logic meta;

      // The first stage feeds only the second stage.
      always_ff @(posedge clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
        begin
          meta      <= 1'b0;
          sync_o[g] <= 1'b0;
        end
        else
        begin
          meta      <= async_i[g];
          sync_o[g] <= meta;
        end
      end
    end
  endgenerate

endmodule

// [logic/obpd_regs.sv]
// Serial-port register slice: pin buffer disables, sleep mask, sync/ref.
module obpd_regs
  import obpd_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        RSTN_I,
  input  wire logic        SPI_CSN_I,
  input  wire logic        SPI_SCLK_I,
  input  wire logic        SPI_MOSI_I,
  output logic             SPI_MISO_O,
  input  wire logic        WHOLE_CHIP_SLEEP_I,
  input  wire logic        SYNC_OR_SLEEP_PIN_I,
  input  wire logic [1:0]  REFERENCE_STRAP_PIN_I,
  output logic [23:0]      PIN_BUFFER_OFF_BITS_O,
  output logic             SLEEP_ACTIVE_O,
  output logic             BIAS_CURRENTS_ON_O,
  output logic             SAMPLE_CLOCK_BUFFER_ON_O,
  output logic             REFERENCE_AMPLIFIER_ON_O,
  output logic             BANDGAP_ON_O,
  output logic             SYNC_PULSE_O,
  output logic [1:0]       REFERENCE_SELECT_O,
  output logic             SINGLE_ENDED_CLOCK_SELECT_O
);

  import obpd_pkg::*;

  // ***************************************************************
  // Pin synchronisers
  // ***************************************************************
  logic [5:0]      pins_sync;
  logic            csn_s;
  logic            sclk_s;
  logic            mosi_s;
  logic            sync_pin_s;
  logic [1:0]      strap_s;
  logic            sclk_d;
  logic            sync_pin_d;
  logic            sclk_rise;
  logic            sclk_fall;

  obpd_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .clk_i   (CLK_SYS_I),
    .rst_n_i (RSTN_I),
    .async_i ({REFERENCE_STRAP_PIN_I, SYNC_OR_SLEEP_PIN_I,
               SPI_MOSI_I, SPI_SCLK_I, SPI_CSN_I}),
    .sync_o  (pins_sync)
  );

  // Unpack the synchronised levels.
  assign csn_s      = pins_sync[0];
  assign sclk_s     = pins_sync[1];
  assign mosi_s     = pins_sync[2];
  assign sync_pin_s = pins_sync[3];
  assign strap_s    = pins_sync[5:4];

  // Delayed copies for edge detection, taken after the synchroniser.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sclk_d     <= 1'b0;
      sync_pin_d <= 1'b0;
    end
    else
    begin
      sclk_d     <= sclk_s;
      sync_pin_d <= sync_pin_s;
    end
  end

  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;

  // ***************************************************************
  // Serial control port
  // ***************************************************************
  obpd_spi_state_e state;
  logic [3:0]      bit_cnt;
  logic [7:0]      rx_shift;
  logic [7:0]      tx_shift;
  logic [6:0]      frame_addr;
  logic            frame_read;
  logic            wr_stb;
  logic [7:0]      wr_data;
  logic [7:0]      rd_data;
  logic [7:0]      buf_off_low;
  logic [7:0]      buf_off_mid;
  logic [7:0]      buf_off_high;
  logic [7:0]      sleep_mask;
  logic [7:0]      sync_ref;
  logic [7:0]      next_rx;

  assign next_rx = {rx_shift[6:0], mosi_s};

  // Frame sequencer; deselect aborts a frame at any point, so a short
  // frame never commits a partial write.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= 4'h0;
      rx_shift   <= 8'h00;
      frame_addr <= 7'h00;
      frame_read <= 1'b0;
    end
    else if (csn_s)
    begin
      state   <= ST_IDLE;
      bit_cnt <= 4'h0;
    end
    else
    begin
      case (state)
        ST_IDLE:
          state <= ST_HEAD;
        ST_HEAD:
          if (sclk_rise)
          begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 4'h1;
            if (bit_cnt == HEAD_LAST_BIT)
            begin
              frame_read <= next_rx[READ_FLAG_BIT];
              frame_addr <= next_rx[6:0];
              state      <= ST_DATA;
            end
          end
        ST_DATA:
          if (sclk_rise)
          begin
            rx_shift <= next_rx;
            bit_cnt  <= bit_cnt + 4'h1;
            if (bit_cnt == FRAME_LAST_BIT)
            begin
              state <= ST_DONE;
            end
          end
        ST_DONE:
          state <= ST_DONE;
        default:
          state <= ST_IDLE;
      endcase
    end
  end

  // Write strobe on the last data bit of a write frame.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      wr_stb  <= 1'b0;
      wr_data <= 8'h00;
    end
    else
    begin
      wr_stb  <= !csn_s && state == ST_DATA && sclk_rise &&
                 bit_cnt == FRAME_LAST_BIT && !frame_read;
      wr_data <= next_rx;
    end
  end

  // Read data returns every stored bit, reserved ones included.
  // The decode looks at the header byte as it completes: frame_addr is
  // only loaded on that same edge, so it would still hold the address
  // of the previous frame when the read shifter is loaded.
  always_comb
  begin
    case (next_rx[6:0])
      ADDR_BUF_OFF_LOW:  rd_data = buf_off_low;
      ADDR_BUF_OFF_MID:  rd_data = buf_off_mid;
      ADDR_BUF_OFF_HIGH: rd_data = buf_off_high;
      ADDR_SLEEP_MASK:   rd_data = sleep_mask;
      ADDR_SYNC_REF:     rd_data = sync_ref;
      default:           rd_data = READ_UNMAPPED;
    endcase
  end

  // Read shifter: loaded when the header completes, shifted out on the
  // falling serial clock so the host samples on the next rising edge.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      tx_shift   <= 8'h00;
      SPI_MISO_O <= 1'b0;
    end
    else if (csn_s)
    begin
      SPI_MISO_O <= 1'b0;
    end
    else if (state == ST_DATA && frame_read && sclk_fall)
    begin
      SPI_MISO_O <= tx_shift[7];
      tx_shift   <= {tx_shift[6:0], 1'b0};
    end
    else if (state == ST_HEAD && sclk_rise && bit_cnt == HEAD_LAST_BIT)
    begin
      tx_shift <= rd_data;
    end
  end

  // ***************************************************************
  // Register file
  // ***************************************************************
  // Buffer-off registers store whatever mode pattern the host chooses.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      buf_off_low  <= RST_BUF_OFF;
      buf_off_mid  <= RST_BUF_OFF;
      buf_off_high <= RST_BUF_OFF;
    end
    else if (wr_stb)
    begin
      if (frame_addr == ADDR_BUF_OFF_LOW)
        buf_off_low <= wr_data;
      if (frame_addr == ADDR_BUF_OFF_MID)
        buf_off_mid <= wr_data;
      if (frame_addr == ADDR_BUF_OFF_HIGH)
        buf_off_high <= wr_data;
    end
  end

  // Sleep mask and sync/reference control, both cleared at reset.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      sleep_mask <= RST_SLEEP_MASK;
      sync_ref   <= RST_SYNC_REF;
    end
    else if (wr_stb)
    begin
      if (frame_addr == ADDR_SLEEP_MASK)
        sleep_mask <= wr_data;
      if (frame_addr == ADDR_SYNC_REF)
        sync_ref <= wr_data;
    end
  end

  // ***************************************************************
  // Power-down, sync and reference outputs
  // ***************************************************************
  logic sleep_now;
  logic pin_sync_sel;
  logic reg_sync_fire;

  assign pin_sync_sel = sync_ref[PIN_SYNC_SELECT_BIT];

  // Sleep from the control bit or from the shared pin in sleep mode.
  assign sleep_now = WHOLE_CHIP_SLEEP_I |
                     (sync_pin_s & ~pin_sync_sel);

  // A write that flips the trigger while enabled fires once; the bit is
  // not self-clearing, so the next toggle in either direction fires too.
  assign reg_sync_fire = wr_stb && frame_addr == ADDR_SYNC_REF &&
                         wr_data[REG_SYNC_ENABLE_BIT] &&
                         (wr_data[REG_SYNC_TRIGGER_BIT] !=
                          sync_ref[REG_SYNC_TRIGGER_BIT]);

  // Block enables: each keep bit overrides sleep for its block.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      SLEEP_ACTIVE_O           <= 1'b0;
      BIAS_CURRENTS_ON_O       <= 1'b1;
      SAMPLE_CLOCK_BUFFER_ON_O <= 1'b1;
      REFERENCE_AMPLIFIER_ON_O <= 1'b1;
      BANDGAP_ON_O             <= 1'b1;
    end
    else
    begin
      SLEEP_ACTIVE_O           <= sleep_now;
      BIAS_CURRENTS_ON_O       <= ~sleep_now |
                                  sleep_mask[KEEP_BIAS_CURRENTS_BIT];
      SAMPLE_CLOCK_BUFFER_ON_O <= ~sleep_now |
        sleep_mask[KEEP_SAMPLE_CLOCK_BUFFER_BIT];
      REFERENCE_AMPLIFIER_ON_O <= ~sleep_now |
        sleep_mask[KEEP_REFERENCE_AMPLIFIER_BIT];
      BANDGAP_ON_O             <= ~sleep_now |
        ~sleep_mask[DROP_BANDGAP_IN_SLEEP_BIT];
    end
  end

  // Sync pulse from a pin rising edge in sync mode or a register toggle.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      SYNC_PULSE_O <= 1'b0;
    end
    else
    begin
      SYNC_PULSE_O <= (sync_pin_s & ~sync_pin_d & pin_sync_sel) |
                      reg_sync_fire;
    end
  end

  // Reference and clock-input selection; the strap rules the reference and the
  // single-ended clock select stays low, unless the register takes over.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
    begin
      REFERENCE_SELECT_O          <= REF_INTERNAL;
      SINGLE_ENDED_CLOCK_SELECT_O <= 1'b0;
    end
    else if (sync_ref[REFERENCE_SOURCE_CONTROL_BIT])
    begin
      REFERENCE_SELECT_O <= sync_ref[REFERENCE_SELECT_HI_BIT:
                                     REFERENCE_SELECT_LO_BIT];
      SINGLE_ENDED_CLOCK_SELECT_O <=
        sync_ref[SINGLE_ENDED_CLOCK_SELECT_BIT];
    end
    else
    begin
      REFERENCE_SELECT_O          <= strap_s;
      SINGLE_ENDED_CLOCK_SELECT_O <= 1'b0;
    end
  end

  // Buffer-off bits registered out, high register in the top byte.
  always_ff @(posedge CLK_SYS_I or negedge RSTN_I)
  begin
    if (!RSTN_I)
      PIN_BUFFER_OFF_BITS_O <= {3{RST_BUF_OFF}};
    else
      PIN_BUFFER_OFF_BITS_O <= {buf_off_high, buf_off_mid, buf_off_low};
  end

endmodule

// [sim/obpd_regs_properties.sv]
// Concurrent checks on the ports of the register slice.
module obpd_regs_properties (
  input wire logic        CLK_SYS_I,
  input wire logic        RSTN_I,
  input wire logic        WHOLE_CHIP_SLEEP_I,
  input wire logic        SYNC_OR_SLEEP_PIN_I,
  input wire logic [23:0] PIN_BUFFER_OFF_BITS_O,
  input wire logic        SLEEP_ACTIVE_O,
  input wire logic        BIAS_CURRENTS_ON_O,
  input wire logic        SAMPLE_CLOCK_BUFFER_ON_O,
  input wire logic        REFERENCE_AMPLIFIER_ON_O,
  input wire logic        BANDGAP_ON_O,
  input wire logic        SYNC_PULSE_O,
  input wire logic [1:0]  REFERENCE_SELECT_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking dc @(posedge CLK_SYS_I);
  endclocking
  default disable iff (!RSTN_I);
  // Awake for two samples, so a wake-up still in flight is not judged.
  property p_on_awake(logic on);
    !SLEEP_ACTIVE_O && !$past(SLEEP_ACTIVE_O) |-> on;
  endproperty
  a_awake_bias_on: assert property (p_on_awake(BIAS_CURRENTS_ON_O))
    else $error("bias off while awake");
  a_awake_clkbuf_on: assert property (
    p_on_awake(SAMPLE_CLOCK_BUFFER_ON_O))
    else $error("clock buffer off while awake");
  a_awake_refamp_on: assert property (
    p_on_awake(REFERENCE_AMPLIFIER_ON_O))
    else $error("reference amplifier off while awake");
  a_awake_bandgap_on: assert property (p_on_awake(BANDGAP_ON_O))
    else $error("bandgap off while awake");
  a_sleep_follows_ctl: assert property (
    WHOLE_CHIP_SLEEP_I |-> ##[1:2] SLEEP_ACTIVE_O)
    else $error("sleep control ignored");
  a_sleep_clears_idle: assert property (
    (!WHOLE_CHIP_SLEEP_I && !SYNC_OR_SLEEP_PIN_I) [*5] |-> !SLEEP_ACTIVE_O)
    else $error("sleep held with no cause");
  a_wake_restores_all: assert property (
    $fell(SLEEP_ACTIVE_O) |-> ##[0:1] (BIAS_CURRENTS_ON_O &&
      SAMPLE_CLOCK_BUFFER_ON_O && REFERENCE_AMPLIFIER_ON_O && BANDGAP_ON_O))
    else $error("blocks not restored on wake");
  a_sync_single_pulse: assert property (SYNC_PULSE_O |=> !SYNC_PULSE_O)
    else $error("sync pulse longer than one cycle");
  a_reset_values_seen: assert property (
    $rose(RSTN_I) |-> PIN_BUFFER_OFF_BITS_O == 24'h0 && !SLEEP_ACTIVE_O
      && !SYNC_PULSE_O && REFERENCE_SELECT_O == 2'h0)
    else $error("outputs not at reset values");
  c_sleep: cover property ($rose(SLEEP_ACTIVE_O));
  c_sync: cover property (SYNC_PULSE_O);
  c_bandgap_drop: cover property ($fell(BANDGAP_ON_O));
endmodule
bind obpd_regs obpd_regs_properties obpd_regs_properties_i (
  .CLK_SYS_I                (CLK_SYS_I),
  .RSTN_I                   (RSTN_I),
  .WHOLE_CHIP_SLEEP_I       (WHOLE_CHIP_SLEEP_I),
  .SYNC_OR_SLEEP_PIN_I      (SYNC_OR_SLEEP_PIN_I),
  .PIN_BUFFER_OFF_BITS_O    (PIN_BUFFER_OFF_BITS_O),
  .SLEEP_ACTIVE_O           (SLEEP_ACTIVE_O),
  .BIAS_CURRENTS_ON_O       (BIAS_CURRENTS_ON_O),
  .SAMPLE_CLOCK_BUFFER_ON_O (SAMPLE_CLOCK_BUFFER_ON_O),
  .REFERENCE_AMPLIFIER_ON_O (REFERENCE_AMPLIFIER_ON_O),
  .BANDGAP_ON_O             (BANDGAP_ON_O),
  .SYNC_PULSE_O             (SYNC_PULSE_O),
  .REFERENCE_SELECT_O       (REFERENCE_SELECT_O)
);

// [sim/obpd_host_model.sv]
// Behavioural serial host that sends frames to the register slice.
module obpd_host_model (
  input  wire logic       clk_i,
  input  wire logic       miso_i,
  output logic            csn_o,
  output logic            sclk_o,
  output logic            mosi_o,
  output logic            rd_done_o,
  output logic [7:0]      rd_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  int half = 6;
  // Idle lines; the link clock stands still outside frames.
  initial
  begin
    csn_o = 1'b1;
    sclk_o = 1'b0;
    mosi_o = 1'b0;
    rd_done_o = 1'b0;
    rd_data_o = 8'h00;
  end
  // One frame MSB first; read data is taken just before each rise.
  task automatic xfer(input logic rd, input logic [6:0] a,
                      input logic [7:0] d);
    logic [15:0] f;
    f = {rd, a, d};
    @(posedge clk_i) #1;
    csn_o = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      mosi_o = f[i];
      repeat (half) @(posedge clk_i);
      #1;
      if (i < 8) rd_data_o[i] = miso_i;
      sclk_o = 1'b1;
      repeat (half) @(posedge clk_i);
      #1 sclk_o = 1'b0;
    end
    repeat (half) @(posedge clk_i);
    #1 csn_o = 1'b1;
    // A released data line must not keep showing its last bit.
    mosi_o = ~mosi_o;
    rd_done_o = rd;
    @(posedge clk_i) #1 rd_done_o = 1'b0;
    // Return just after an edge, so the caller never drives on one.
    repeat (4) @(posedge clk_i);
    #1;
  endtask
endmodule

// [sim/tb_obpd_regs.sv]
// Self-checking bench for the buffer-off, sleep mask and sync/ref slice.
module tb_obpd_regs;
  timeunit 1ns;
  timeprecision 1ps;
  import obpd_pkg::*;
  logic        clk, rstn, csn, sclk, mosi, miso, sleep, pin, sync, se, sl;
  logic        bias, cbuf, ramp, bg, rd_done;
  logic [1:0]  strap, rsel;
  logic [7:0]  rd_data, m;
  logic [23:0] boff;
  logic [7:0]  exp_q[$];
  int          error_cnt, n_tests, pulses, p0;
  logic [6:0]  adr[5] = '{ADDR_BUF_OFF_LOW, ADDR_BUF_OFF_MID,
                          ADDR_BUF_OFF_HIGH, ADDR_SLEEP_MASK, ADDR_SYNC_REF};
  logic [23:0] modes[4] = '{24'h0c1e60, 24'h0cfe7f, 24'hfcefff, 24'hfdefff};

  obpd_regs obpd_regs_i (
    .CLK_SYS_I                   (clk),
    .RSTN_I                      (rstn),
    .SPI_CSN_I                   (csn),
    .SPI_SCLK_I                  (sclk),
    .SPI_MOSI_I                  (mosi),
    .SPI_MISO_O                  (miso),
    .WHOLE_CHIP_SLEEP_I          (sleep),
    .SYNC_OR_SLEEP_PIN_I         (pin),
    .REFERENCE_STRAP_PIN_I       (strap),
    .PIN_BUFFER_OFF_BITS_O       (boff),
    .SLEEP_ACTIVE_O              (sl),
    .BIAS_CURRENTS_ON_O          (bias),
    .SAMPLE_CLOCK_BUFFER_ON_O    (cbuf),
    .REFERENCE_AMPLIFIER_ON_O    (ramp),
    .BANDGAP_ON_O                (bg),
    .SYNC_PULSE_O                (sync),
    .REFERENCE_SELECT_O          (rsel),
    .SINGLE_ENDED_CLOCK_SELECT_O (se)
  );
  obpd_host_model host_i (
    .clk_i     (clk),
    .miso_i    (miso),
    .csn_o     (csn),
    .sclk_o    (sclk),
    .mosi_o    (mosi),
    .rd_done_o (rd_done),
    .rd_data_o (rd_data)
  );
  // Free-running system clock, 8 ns period.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, exp, input string s);
    n_tests++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  task automatic conclude();
    chk(exp_q.size(), 32'h0, "reads never answered");
    $display("Counts: %0d checks, %0d errors", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host_i.xfer(1'b0, a, d);
  endtask
  // The expected byte is noted first; the monitor compares on arrival.
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host_i.xfer(1'b1, a, 8'($urandom));
  endtask
  task automatic do_reset();
    @(posedge clk) #1 rstn = 1'b0;
    step(4);
    rstn = 1'b1;
    step(3);
  endtask
  // Monitor: each finished read takes the oldest note off the queue.
  always @(posedge clk)
  begin
    if (rd_done === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk(32'h1, 32'h0, "read with no note");
      else
        chk(rd_data, exp_q.pop_front(), "readback");
    end
    if (sync === 1'b1) pulses++;
  end
  // Hang guard: a run this long counts as a failure.
  initial
  begin
    repeat (90000) @(posedge clk);
    error_cnt++;
    conclude();
  end
  initial
  begin
    rstn = 1'b0;
    sleep = 1'b0;
    pin = 1'b0;
    strap = 2'h2;
    error_cnt = 0;
    n_tests = 0;
    pulses = 0;
    void'($urandom(32'hadc5a044));
    do_reset();
    foreach (adr[i]) rd(adr[i], 8'h00);
    rd(7'h0f, READ_UNMAPPED);
    chk({bias, cbuf, ramp, bg}, 4'hf, "awake after reset");
    $display("test reset done");
    // Pin-buffer pattern of every output mode, written and read back.
    for (int i = 0; i < 4; i++)
    begin
      for (int j = 0; j < 3; j++) wr(adr[j], modes[i][8*j +: 8]);
      chk(boff, modes[i], "buffer pattern");
      for (int j = 0; j < 3; j++) rd(adr[j], modes[i][8*j +: 8]);
    end
    wr(7'h0f, 8'hff);
    rd(7'h0f, READ_UNMAPPED);
    $display("test modes done");
    // Keep masks: none, all, then random picks of the four fields.
    for (int i = 0; i < 4; i++)
    begin
      m = (i < 2) ? (i ? 8'h2e : 8'h00) : 8'($urandom) & 8'h2e;
      wr(ADDR_SLEEP_MASK, m);
      sleep = 1'b1;
      step(3);
      chk(sl, 1'b1, "sleep entered");
      chk({bias, cbuf, ramp, bg}, {m[5], m[3], m[2], ~m[1]}, "mask");
      sleep = 1'b0;
      step(3);
      chk({sl, bias, cbuf, ramp, bg}, 5'h0f, "wake");
      rd(ADDR_SLEEP_MASK, m);
    end
    $display("test mask done");
    // Shared pin as sleep, then as sync trigger.
    wr(ADDR_SYNC_REF, 8'h00);
    pin = 1'b1;
    step(5);
    chk(sl, 1'b1, "pin sleep");
    pin = 1'b0;
    step(5);
    wr(ADDR_SYNC_REF, 8'h80);
    p0 = pulses;
    pin = 1'b1;
    step(8);
    chk(32'(pulses - p0), 32'h1, "pin sync");
    chk(sl, 1'b0, "no sleep in sync mode");
    pin = 1'b0;
    $display("test pin done");
    // Register trigger, driven by a slow host this time.
    host_i.half = 10;
    wr(ADDR_SYNC_REF, 8'h20);
    p0 = pulses;
    wr(ADDR_SYNC_REF, 8'h60);
    chk(32'(pulses - p0), 32'h1, "trigger toggle");
    wr(ADDR_SYNC_REF, 8'h60);
    wr(ADDR_SYNC_REF, 8'h20);
    wr(ADDR_SYNC_REF, 8'h40);
    chk(32'(pulses - p0), 32'h2, "trigger count");
    host_i.half = 6;
    $display("test trigger done");
    // Strap rules with control clear; register codes with it set.
    wr(ADDR_SYNC_REF, 8'h01);
    chk({rsel, se}, {strap, 1'b0}, "strap select");
    for (int c = 0; c < 3; c++)
    begin
      m = 8'h09 | 8'(c << 1);
      wr(ADDR_SYNC_REF, m);
      chk({rsel, se}, {2'(c), 1'b1}, "register select");
      rd(ADDR_SYNC_REF, m);
    end
    $display("test reference done");
    // A second reset in mid-run clears what was written.
    wr(ADDR_SLEEP_MASK, 8'h2e);
    do_reset();
    rd(ADDR_SLEEP_MASK, 8'h00);
    rd(ADDR_SYNC_REF, 8'h00);
    $display("test second reset done");
    step(20);
    conclude();
  end
endmodule
